/* hdl/flash_seq_pkg.sv */
// constants and types for the program/erase/suspend sequencer
package flash_seq_pkg;
  localparam logic [7:0] OP_PP3 = 8'h02;
  localparam logic [7:0] OP_OFP3 = 8'h82;
  localparam logic [7:0] OP_XOFP3 = 8'hC2;
  localparam logic [7:0] OP_PP4 = 8'h12;
  localparam logic [7:0] OP_OFP4 = 8'h84;
  localparam logic [7:0] OP_XOFP4 = 8'h8E;
  localparam logic [7:0] OP_SSE4K = 8'h20;
  localparam logic [7:0] OP_SSE32K = 8'h52;
  localparam logic [7:0] OP_SE = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RES = 8'h7A;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_CLFSR = 8'h50;
  localparam logic [7:0] OP_EN4B = 8'hB7;
  localparam logic [7:0] OP_EX4B = 8'hE9;
  // flag status bit positions
  localparam int FSR_READY = 7;
  localparam int FSR_ESUSP = 6;
  localparam int FSR_EERR = 5;
  localparam int FSR_PERR = 4;
  localparam int FSR_PSUSP = 2;
  localparam int FSR_PROT = 1;
  localparam logic [7:0] FSR_RST = 8'h80;
  localparam logic [7:0] FSR_ERR_M = 8'h32;
  // register offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PROT = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_CLR = 4'hC;
  localparam int CTL_OCTAL = 0;
  localparam int CTL_ADDR4 = 1;
  localparam int CTL_PROT_EN = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int PROT_HI_LSB = 16;
  localparam int SEC_LSB = 17;
  // timing
  localparam int CLK_NS = 100;
  localparam int PP_TIME_US = 200;
  localparam int SSE_TIME_MS = 50;
  localparam int SE_TIME_MS = 150;
  localparam int BE_TIME_S = 60;
  localparam int SUSP_LAT_US = 20;
  localparam logic [31:0] PP_CYC = 32'(PP_TIME_US * 1000 / CLK_NS);
  localparam logic [31:0] SSE_CYC = 32'(SSE_TIME_MS * (1000000 / CLK_NS));
  localparam logic [31:0] SE_CYC = 32'(SE_TIME_MS * (1000000 / CLK_NS));
  localparam logic [31:0] BE_CYC = 32'(BE_TIME_S * (1000000000 / CLK_NS));
  localparam logic [31:0] LAT_CYC = 32'(SUSP_LAT_US * 1000 / CLK_NS);
  typedef logic [1:0] ekind_t;
  localparam ekind_t EK_4K = 2'h0;
  localparam ekind_t EK_32K = 2'h1;
  localparam ekind_t EK_SEC = 2'h2;
  localparam ekind_t EK_CHIP = 2'h3;
  typedef enum logic [3:0] {
    LK_CMD = 4'b0001, LK_EXT = 4'b0010, LK_ADDR = 4'b0100, LK_DATA = 4'b1000
  } link_e;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001, ENG_RUN = 3'b010, ENG_SUSP = 3'b100
  } eng_e;
endpackage

/* hdl/flash_seq.sv */
// program/erase/suspend command sequencer of the serial flash
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_seq #(
  parameter logic [31:0] PP_CYC = flash_seq_pkg::PP_CYC,
  parameter logic [31:0] SSE_CYC = flash_seq_pkg::SSE_CYC,
  parameter logic [31:0] SE_CYC = flash_seq_pkg::SE_CYC,
  parameter logic [31:0] BE_CYC = flash_seq_pkg::BE_CYC,
  parameter logic [31:0] LAT_CYC = flash_seq_pkg::LAT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [7:0] serial_io_lines,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // array side
  input wire logic arr_fail,
  output logic arr_erase,
  output flash_seq_pkg::ekind_t arr_erase_kind,
  output logic [31:0] arr_erase_addr,
  output logic arr_we,
  output logic [31:0] arr_waddr,
  output logic [7:0] arr_wdata
);
  import flash_seq_pkg::*;

  function automatic logic is_prog(input logic [7:0] op);
    return op == OP_PP3 || op == OP_OFP3 || op == OP_XOFP3 || op == OP_PP4 ||
           op == OP_OFP4 || op == OP_XOFP4;
  endfunction

  function automatic logic is_a4op(input logic [7:0] op);
    return op == OP_PP4 || op == OP_OFP4 || op == OP_XOFP4;
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_SSE4K || op == OP_SSE32K || op == OP_SE || op == OP_CE1 ||
           op == OP_CE2;
  endfunction

  function automatic logic has_addr(input logic [7:0] op);
    return is_prog(op) || (is_erase(op) && op != OP_CE1 && op != OP_CE2);
  endfunction

  function automatic logic prot(input logic [31:0] a, input logic en,
                                input logic [8:0] lo, input logic [8:0] hi);
    return en && a[SEC_LSB+8:SEC_LSB] >= lo && a[SEC_LSB+8:SEC_LSB] <= hi;
  endfunction

  // input synchronisers
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic [7:0] dq_s1_q, dq_s2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ck_s1_q <= sclk;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dq_s1_q <= serial_io_lines;
      dq_s2_q <= dq_s1_q;
    end
  end

  // link state
  link_e lk_q, lk_d;
  logic [7:0] sh_q, sh_d, op_q, op_d, off_q, off_d, byte_v;
  logic [2:0] bit_q, bit_d;
  logic [31:0] addr_q, addr_d;
  logic [1:0] acnt_q, acnt_d, alen_q, alen_d;
  logic bad_q, bad_d, go_q, go_d, byte_ok, bw_en, octal, ck_rise, ck_fall;
  logic [255:0] vmask_q, vmask_d;
  logic [7:0] pbuf [256];

  // core state
  eng_e eng_q, eng_d;
  logic e_act_q, e_act_d, e_susp_q, e_susp_d, p_act_q, p_act_d, p_susp_q, p_susp_d;
  ekind_t e_kind_q, e_kind_d, arr_ekind_q, arr_ekind_d;
  logic [31:0] e_addr_q, e_addr_d, p_addr_q, p_addr_d, e_rem_q, e_rem_d;
  logic [31:0] p_rem_q, p_rem_d, lat_q, lat_d, rem;
  logic run_p_q, run_p_d, wip_q, wip_d, wel_q, wel_d, a4_q, a4_d;
  logic [7:0] fsr_q, fsr_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [8:0] plo_q, plo_d, phi_q, phi_d, dptr_q, dptr_d;
  logic arr_erase_q, arr_erase_d, arr_we_q, arr_we_d;
  logic [31:0] arr_eaddr_q, arr_eaddr_d, arr_waddr_q, arr_waddr_d, rdata_q, rdata_d;
  logic [7:0] arr_wdata_q, arr_wdata_d;

  always_comb begin
    lk_d = lk_q;
    sh_d = sh_q;
    bit_d = bit_q;
    op_d = op_q;
    addr_d = addr_q;
    acnt_d = acnt_q;
    alen_d = alen_q;
    off_d = off_q;
    bad_d = bad_q;
    go_d = 1'b0;
    vmask_d = vmask_q;
    bw_en = 1'b0;
    byte_ok = 1'b0;
    byte_v = 8'h00;
    octal = ctrl_q[CTL_OCTAL];
    ck_rise = ck_s2_q & ~ck_s3_q;
    ck_fall = ~ck_s2_q & ck_s3_q;
    if (cs_s3_q & ~cs_s2_q) begin
      lk_d = LK_CMD;
      bit_d = 3'd0;
      acnt_d = 2'd0;
      addr_d = 32'h0;
      bad_d = 1'b0;
      // a running or suspended program still owns the page buffer
      if (!p_act_q) begin
        vmask_d = '0;
      end
    end else if (~cs_s2_q & (ck_rise | (octal & ck_fall))) begin
      if (octal) begin
        byte_ok = 1'b1;
        byte_v = dq_s2_q;
      end else begin
        sh_d = {sh_q[6:0], dq_s2_q[0]};
        bit_d = bit_q + 3'd1;
        if (bit_q == 3'd7) begin
          byte_ok = 1'b1;
          byte_v = sh_d;
        end
      end
    end else if (cs_s2_q & ~cs_s3_q) begin
      go_d = lk_q == LK_DATA && bit_q == 3'd0 && !bad_q;
    end
    if (byte_ok) begin
      case (lk_q)
        LK_CMD: begin
          op_d = byte_v;
          alen_d = (octal | a4_q | is_a4op(byte_v)) ? 2'd3 : 2'd2;
          if (octal) begin
            lk_d = LK_EXT;
          end else begin
            lk_d = has_addr(byte_v) ? LK_ADDR : LK_DATA;
          end
        end
        LK_EXT: begin
          lk_d = has_addr(op_q) ? LK_ADDR : LK_DATA;
        end
        LK_ADDR: begin
          addr_d = {addr_q[23:0], byte_v};
          acnt_d = acnt_q + 2'd1;
          if (acnt_q == alen_q) begin
            lk_d = LK_DATA;
            off_d = byte_v;
          end
        end
        LK_DATA: begin
          if (is_prog(op_q)) begin
            if (!p_act_q) begin
              bw_en = 1'b1;
              vmask_d[off_q] = 1'b1;
            end
            off_d = off_q + 8'd1;
          end else begin
            bad_d = 1'b1;
          end
        end
        default: lk_d = LK_CMD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lk_q <= LK_CMD;
      sh_q <= 8'h00;
      bit_q <= 3'd0;
      op_q <= 8'h00;
      addr_q <= 32'h0;
      acnt_q <= 2'd0;
      alen_q <= 2'd0;
      off_q <= 8'h00;
      bad_q <= 1'b0;
      go_q <= 1'b0;
      vmask_q <= '0;
    end else begin
      lk_q <= lk_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      op_q <= op_d;
      addr_q <= addr_d;
      acnt_q <= acnt_d;
      alen_q <= alen_d;
      off_q <= off_d;
      bad_q <= bad_d;
      go_q <= go_d;
      vmask_q <= vmask_d;
    end
  end

  // page buffer keeps only the last byte per offset
  always_ff @(posedge clk) begin
    if (bw_en) begin
      pbuf[off_q] <= byte_v;
    end
  end

  always_comb begin
    eng_d = eng_q;
    e_act_d = e_act_q;
    e_susp_d = e_susp_q;
    e_kind_d = e_kind_q;
    e_addr_d = e_addr_q;
    e_rem_d = e_rem_q;
    p_act_d = p_act_q;
    p_susp_d = p_susp_q;
    p_addr_d = p_addr_q;
    p_rem_d = p_rem_q;
    run_p_d = run_p_q;
    lat_d = lat_q;
    fsr_d = fsr_q;
    wip_d = wip_q;
    wel_d = wel_q;
    a4_d = a4_q;
    ctrl_d = ctrl_q;
    plo_d = plo_q;
    phi_d = phi_q;
    dptr_d = dptr_q;
    arr_erase_d = 1'b0;
    arr_ekind_d = arr_ekind_q;
    arr_eaddr_d = arr_eaddr_q;
    arr_we_d = 1'b0;
    arr_waddr_d = arr_waddr_q;
    arr_wdata_d = arr_wdata_q;
    rdata_d = 32'h0;
    rem = run_p_q ? p_rem_q : e_rem_q;
    // software clears first so that a flag set in the same cycle survives
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_d = reg_wdata[2:0];
        a4_d = reg_wdata[CTL_ADDR4];
      end else if (reg_addr == REG_PROT) begin
        plo_d = reg_wdata[8:0];
        phi_d = reg_wdata[PROT_HI_LSB+8:PROT_HI_LSB];
      end else if (reg_addr == REG_CLR) begin
        fsr_d = fsr_q & ~FSR_ERR_M;
      end
    end
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        rdata_d = {29'h0, ctrl_q};
      end else if (reg_addr == REG_PROT) begin
        rdata_d = {7'h0, phi_q, 7'h0, plo_q};
      end else if (reg_addr == REG_STAT) begin
        rdata_d = {21'h0, a4_q, wel_q, wip_q, fsr_q};
      end
    end
    if (go_q) begin
      if (op_q == OP_WREN) begin
        wel_d = 1'b1;
      end else if (op_q == OP_WRDI) begin
        wel_d = 1'b0;
      end else if (op_q == OP_EN4B) begin
        a4_d = 1'b1;
      end else if (op_q == OP_EX4B) begin
        a4_d = 1'b0;
      end else if (op_q == OP_CLFSR) begin
        fsr_d = fsr_d & ~FSR_ERR_M;
      end else if (is_prog(op_q)) begin
        if (wel_q && eng_q == ENG_IDLE && !p_act_q) begin
          if (e_act_q && addr_q[31:SEC_LSB] == e_addr_q[31:SEC_LSB]) begin
            fsr_d[FSR_PERR] = 1'b1;
          end else if (prot(addr_q, ctrl_q[CTL_PROT_EN], plo_q, phi_q)) begin
            fsr_d[FSR_PROT] = 1'b1;
            fsr_d[FSR_PERR] = 1'b1;
          end else begin
            p_act_d = 1'b1;
            p_addr_d = addr_q;
            p_rem_d = PP_CYC;
            run_p_d = 1'b1;
            eng_d = ENG_RUN;
            wip_d = 1'b1;
            fsr_d[FSR_READY] = 1'b0;
            dptr_d = 9'd0;
          end
        end
      end else if (is_erase(op_q)) begin
        // latch clear: silently dropped, no flag
        if (wel_q && eng_q == ENG_IDLE && !e_act_q && !p_act_q) begin
          if (op_q == OP_CE1 || op_q == OP_CE2) begin
            e_kind_d = EK_CHIP;
          end else if (op_q == OP_SE) begin
            e_kind_d = EK_SEC;
          end else if (op_q == OP_SSE32K) begin
            e_kind_d = EK_32K;
          end else begin
            e_kind_d = EK_4K;
          end
          if (e_kind_d == EK_CHIP ? ctrl_q[CTL_PROT_EN]
              : prot(addr_q, ctrl_q[CTL_PROT_EN], plo_q, phi_q)) begin
            fsr_d[FSR_PROT] = 1'b1;
            fsr_d[FSR_EERR] = 1'b1;
            e_kind_d = e_kind_q;
          end else begin
            e_act_d = 1'b1;
            e_addr_d = addr_q;
            e_rem_d = e_kind_d == EK_CHIP ? BE_CYC : e_kind_d == EK_SEC ? SE_CYC
                      : SSE_CYC;
            run_p_d = 1'b0;
            eng_d = ENG_RUN;
            wip_d = 1'b1;
            fsr_d[FSR_READY] = 1'b0;
          end
        end
      end else if (op_q == OP_SUSP && eng_q == ENG_RUN && (run_p_q || e_kind_q != EK_CHIP)) begin
        fsr_d[run_p_q ? FSR_PSUSP : FSR_ESUSP] = 1'b1;
        // too close to the end: let it finish, completion drops the flag again
        if (rem > LAT_CYC) begin
          eng_d = ENG_SUSP;
          lat_d = LAT_CYC;
        end
      end else if (op_q == OP_RES && eng_q == ENG_IDLE && (p_susp_q || e_susp_q)) begin
        // no fresh lock check on resume, the erase keeps its original target
        if (p_susp_q) begin
          p_susp_d = 1'b0;
          run_p_d = 1'b1;
          fsr_d[FSR_PSUSP] = 1'b0;
        end else begin
          e_susp_d = 1'b0;
          run_p_d = 1'b0;
          fsr_d[FSR_ESUSP] = 1'b0;
        end
        eng_d = ENG_RUN;
        wip_d = 1'b1;
        fsr_d[FSR_READY] = 1'b0;
      end
    end
    if (eng_q != ENG_IDLE) begin
      if (run_p_q) begin
        p_rem_d = p_rem_q - 32'd1;
        if (!dptr_q[8]) begin
          arr_we_d = vmask_q[dptr_q[7:0]];
          arr_waddr_d = {p_addr_q[31:8], dptr_q[7:0]};
          arr_wdata_d = pbuf[dptr_q[7:0]];
          dptr_d = dptr_q + 9'd1;
        end
      end else begin
        e_rem_d = e_rem_q - 32'd1;
      end
      if (rem == 32'd1) begin
        eng_d = ENG_IDLE;
        wip_d = 1'b0;
        wel_d = 1'b0;
        fsr_d[FSR_READY] = 1'b1;
        if (run_p_q) begin
          p_act_d = 1'b0;
          fsr_d[FSR_PSUSP] = 1'b0;
          fsr_d[FSR_PERR] = fsr_d[FSR_PERR] | arr_fail;
        end else begin
          e_act_d = 1'b0;
          fsr_d[FSR_ESUSP] = 1'b0;
          fsr_d[FSR_EERR] = fsr_d[FSR_EERR] | arr_fail;
          arr_erase_d = 1'b1;
          arr_ekind_d = e_kind_q;
          arr_eaddr_d = e_addr_q;
        end
      end else if (eng_q == ENG_SUSP) begin
        lat_d = lat_q - 32'd1;
        if (lat_q == 32'd1) begin
          // parked until a resume arrives
          eng_d = ENG_IDLE;
          wip_d = 1'b0;
          fsr_d[FSR_READY] = 1'b1;
          if (run_p_q) begin
            p_susp_d = 1'b1;
          end else begin
            e_susp_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eng_q <= ENG_IDLE;
      e_act_q <= 1'b0;
      e_susp_q <= 1'b0;
      e_kind_q <= EK_4K;
      e_addr_q <= 32'h0;
      e_rem_q <= 32'h0;
      p_act_q <= 1'b0;
      p_susp_q <= 1'b0;
      p_addr_q <= 32'h0;
      p_rem_q <= 32'h0;
      run_p_q <= 1'b0;
      lat_q <= 32'h0;
      fsr_q <= FSR_RST;
      wip_q <= 1'b0;
      wel_q <= 1'b0;
      a4_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      plo_q <= 9'h000;
      phi_q <= 9'h000;
      dptr_q <= 9'h100;
      arr_erase_q <= 1'b0;
      arr_ekind_q <= EK_4K;
      arr_eaddr_q <= 32'h0;
      arr_we_q <= 1'b0;
      arr_waddr_q <= 32'h0;
      arr_wdata_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      eng_q <= eng_d;
      e_act_q <= e_act_d;
      e_susp_q <= e_susp_d;
      e_kind_q <= e_kind_d;
      e_addr_q <= e_addr_d;
      e_rem_q <= e_rem_d;
      p_act_q <= p_act_d;
      p_susp_q <= p_susp_d;
      p_addr_q <= p_addr_d;
      p_rem_q <= p_rem_d;
      run_p_q <= run_p_d;
      lat_q <= lat_d;
      fsr_q <= fsr_d;
      wip_q <= wip_d;
      wel_q <= wel_d;
      a4_q <= a4_d;
      ctrl_q <= ctrl_d;
      plo_q <= plo_d;
      phi_q <= phi_d;
      dptr_q <= dptr_d;
      arr_erase_q <= arr_erase_d;
      arr_ekind_q <= arr_ekind_d;
      arr_eaddr_q <= arr_eaddr_d;
      arr_we_q <= arr_we_d;
      arr_waddr_q <= arr_waddr_d;
      arr_wdata_q <= arr_wdata_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign arr_erase = arr_erase_q;
  assign arr_erase_kind = arr_ekind_q;
  assign arr_erase_addr = arr_eaddr_q;
  assign arr_we = arr_we_q;
  assign arr_waddr = arr_waddr_q;
  assign arr_wdata = arr_wdata_q;
endmodule
`default_nettype wire

/* bench/flash_seq_asserts.sv */
// concurrent checks on the sequencer's ports
`timescale 1ns/1ps
`default_nettype none
module flash_seq_asserts
  import flash_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [7:0] serial_io_lines,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // array side
  input wire logic arr_fail,
  input wire logic arr_erase,
  input wire flash_seq_pkg::ekind_t arr_erase_kind,
  input wire logic [31:0] arr_erase_addr,
  input wire logic arr_we,
  input wire logic [31:0] arr_waddr,
  input wire logic [7:0] arr_wdata
);
  logic fresh_q, fresh_d, done_q, done_d, stat_rd;
  // a new frame or register write ends the window in which the flags are known
  always_comb begin
    stat_rd = reg_rd && reg_addr == REG_STAT;
    fresh_d = fresh_q && cs_n && !reg_wr;
    done_d = arr_erase || (done_q && cs_n);
  end
  always_ff @(posedge clk) begin
    fresh_q <= rst ? 1'b1 : fresh_d;
    done_q <= rst ? 1'b0 : done_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence page_step;
    arr_we ##1 arr_we;
  endsequence
  sequence fresh_read;
    stat_rd && fresh_q ##1 1'b1;
  endsequence
  a_erase_single: assert property (arr_erase |=> !arr_erase)
    else $error("erase pulse longer than one cycle");
  a_erase_we_excl: assert property (!(arr_erase && arr_we))
    else $error("program and erase strobes together");
  a_done_status: assert property (stat_rd && done_q |=>
    reg_rdata[9:7] == 3'b001 && !reg_rdata[FSR_ESUSP])
    else $error("status after erase completion wrong");
  a_reset_flags: assert property (fresh_read |-> reg_rdata[10:0] == 11'h080)
    else $error("flags after reset wrong");
  a_busy_not_ready: assert property (stat_rd |=>
    !(reg_rdata[8] && reg_rdata[FSR_READY]))
    else $error("busy and ready together");
  a_susp_no_wip: assert property (stat_rd |=>
    !(reg_rdata[FSR_READY] && (reg_rdata[FSR_ESUSP] || reg_rdata[FSR_PSUSP]) && reg_rdata[8]))
    else $error("suspended operation still busy");
  a_prot_pair: assert property (stat_rd |=>
    !reg_rdata[FSR_PROT] || reg_rdata[FSR_EERR] || reg_rdata[FSR_PERR])
    else $error("protect flag without error flag");
  a_we_in_page: assert property (page_step |->
    arr_waddr[31:8] == $past(arr_waddr[31:8]))
    else $error("program left its page");
endmodule
`default_nettype wire

/* bench/flash_host_model.sv */
// host controller model that frames commands on the link pins
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // clock and link pins
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic [7:0] serial_io_lines
);
  logic [7:0] fq[$];
  int cut = 0;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_io_lines = 8'h00;
  end
  // one link clock edge: data settle, flip, hold; four edges of clk make 400 ns
  task automatic half(input logic [7:0] v);
    serial_io_lines <= v;
    repeat (2) @(posedge clk);
    sclk <= ~sclk;
    repeat (2) @(posedge clk);
  endtask
  task automatic bit_out(input logic b);
    half({7'h00, b});
    half({7'h00, b});
  endtask
  // octal frames need an even byte count so the clock parks low
  task automatic frame(input logic o);
    logic [7:0] b;
    @(posedge clk);
    cs_n <= 1'b0;
    while (fq.size() > 0) begin
      b = fq.pop_front();
      if (o) half(b);
      else for (int i = 7; i >= 0; i--) bit_out(b[i]);
    end
    for (int i = 0; i < cut; i++) bit_out(1'b0);
    cs_n <= 1'b1;
    serial_io_lines <= ~serial_io_lines;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* bench/test_flash_seq.sv */
// self-checking bench for the program/erase/suspend sequencer
`timescale 1ns/1ps
`default_nettype none
module test_flash_seq;
  import flash_seq_pkg::*;
  // shortened counts keep the run brief; every wait derives from them
  localparam logic [31:0] PP = 32'h12C, SSE = 32'h258, SE = 32'h320, BE = 32'h3E8;
  localparam logic [31:0] LAT = 32'h64, ALL = 32'hFFFFFFFF, M9 = 32'h1FF;
  localparam logic [7:0] EC[5] = '{OP_SSE4K, OP_SSE32K, OP_SE, OP_CE1, OP_CE2};
  localparam ekind_t EK[5] = '{EK_4K, EK_32K, EK_SEC, EK_CHIP, EK_CHIP};
  localparam logic [31:0] ET[5] = '{SSE, SSE, SE, BE, BE};
  localparam logic [7:0] PC[4] = '{OP_PP4, OP_OFP4, OP_XOFP4, OP_PP3};
  logic clk, rst, cs_n, sclk, reg_wr, reg_rd, arr_fail, arr_erase, arr_we, rd_seen, oct;
  logic [7:0] serial_io_lines, arr_wdata, d;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, arr_erase_addr, arr_waddr, a;
  ekind_t arr_erase_kind;
  logic [31:0] rq[$], rm[$];
  logic [33:0] eq[$], e;
  logic [39:0] wq[$];
  int miscompares, tests_run, ers_n, sd;
  flash_seq #(.PP_CYC(PP), .SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE), .LAT_CYC(LAT)) i_flash_seq (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .serial_io_lines(serial_io_lines),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .arr_fail(arr_fail), .arr_erase(arr_erase),
    .arr_erase_kind(arr_erase_kind), .arr_erase_addr(arr_erase_addr), .arr_we(arr_we),
    .arr_waddr(arr_waddr), .arr_wdata(arr_wdata));
  flash_host_model i_flash_host_model (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .serial_io_lines(serial_io_lines));
  task automatic tally(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] g, x);
    tally(g === x, "register read");
  endtask
  task automatic cmp_erase(input logic [33:0] g, x);
    tally(g === x, "erase strobe");
  endtask
  task automatic cmp_prog(input logic [39:0] g, x);
    tally(g === x, "program byte");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] x, m);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    rq.push_back(x & m);
    rm.push_back(m);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic st(input logic [31:0] x, m);
    rd(REG_STAT, x, m);
  endtask
  task automatic op(input logic [7:0] c, input int na, input logic [31:0] ad, input int nd,
                    input logic [7:0] v);
    i_flash_host_model.fq.push_back(c);
    if (oct) i_flash_host_model.fq.push_back(8'h00);
    for (int i = na - 1; i >= 0; i--) i_flash_host_model.fq.push_back(ad[8*i+:8]);
    for (int i = 0; i < nd; i++) i_flash_host_model.fq.push_back(v + 8'(i));
    i_flash_host_model.frame(oct);
  endtask
  task automatic cmd(input logic [7:0] c);
    op(c, 0, 32'h0, 0, 8'h00);
  endtask
  // the early check catches an erase that uses a shorter duration
  task automatic wait_ers(input logic [31:0] lo, hi);
    int n0;
    n0 = ers_n;
    repeat (lo) @(posedge clk);
    tally(ers_n == n0, "erase ended early");
    for (int i = 0; i < hi && ers_n == n0; i++) @(posedge clk);
    tally(ers_n != n0, "erase did not end");
  endtask
  always @(posedge clk) begin
    if (rd_seen === 1'b1) cmp_reg(reg_rdata & rm.pop_front(), rq.pop_front());
    rd_seen <= reg_rd;
    if (arr_we === 1'b1) cmp_prog({arr_waddr, arr_wdata}, wq.pop_front());
    if (arr_erase === 1'b1) begin
      ers_n++;
      e = eq.pop_front();
      // chip erase carries no address, so only its kind is compared
      cmp_erase({arr_erase_kind, (e[33:32] == EK_CHIP) ? e[31:0] : arr_erase_addr}, e);
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    tally(1'b0, "watchdog expired");
    print_verdict();
  end
  initial begin
    {rst, reg_wr, reg_rd, arr_fail, oct} = 5'h10;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    sd = $urandom(32'h341757a8);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    st(32'h080, ALL);
    rd(REG_CTRL, 32'h0, ALL);
    rd(4'h2, 32'h0, ALL);
    a = $urandom & 32'h00FFFFFF;
    op(OP_SSE4K, 3, a, 0, 8'h00);
    st(32'h080, ALL);
    cmd(OP_WREN);
    i_flash_host_model.cut = 3;
    op(OP_SSE4K, 3, a, 0, 8'h00);
    i_flash_host_model.cut = 0;
    st(32'h280, ALL);
    for (int k = 0; k < 5; k++) begin
      a = (k < 3) ? ($urandom & 32'h00FFFFFF) : 32'h0;
      arr_fail <= (k == 4);
      cmd(OP_WREN);
      op(EC[k], (k < 3) ? 3 : 0, a, 0, 8'h00);
      st(32'h100, M9);
      eq.push_back({EK[k], a});
      wait_ers(ET[k] - 32'h28, 32'h50);
      st((k == 4) ? 32'h0A0 : 32'h080, ALL);
    end
    arr_fail <= 1'b0;
    wr(REG_CLR, 32'h0);
    wr(REG_CTRL, 32'h4);
    wr(REG_PROT, 32'h0);
    cmd(OP_WREN);
    op(OP_SSE4K, 3, 32'h100, 0, 8'h00);
    st(32'h2A2, ALL);
    cmd(OP_CLFSR);
    cmd(OP_CE2);
    st(32'h2A2, ALL);
    wr(REG_CLR, 32'h0);
    op(OP_PP4, 4, 32'h10, 1, 8'h55);
    st(32'h292, ALL);
    wr(REG_CLR, 32'h0);
    wr(REG_CTRL, 32'h0);
    st(32'h280, ALL);
    cmd(OP_WRDI);
    st(32'h080, ALL);
    for (int k = 0; k < 4; k++) begin
      a = {8'h01, 16'($urandom), 8'hFF};
      d = 8'($urandom);
      if (k == 3) cmd(OP_EN4B);
      if (k == 3) st(32'h480, 32'h4FF);
      cmd(OP_WREN);
      // the array sees offsets in ascending order, so wrapped bytes come first
      wq.push_back({a[31:8], 8'h00, d + 8'h01});
      wq.push_back({a[31:8], 8'h01, d + 8'h02});
      wq.push_back({a, d});
      op(PC[k], 4, a, 3, d);
      st(32'h100, M9);
      repeat (PP) @(posedge clk);
      st(32'h080, 32'h3FF);
    end
    cmd(OP_EX4B);
    wr(REG_CTRL, 32'h1);
    oct = 1'b1;
    cmd(OP_WREN);
    eq.push_back({EK_4K, 32'h00ABCDEF});
    op(OP_SSE4K, 4, 32'h00ABCDEF, 0, 8'h00);
    wait_ers(SSE - 32'h28, 32'h50);
    st(32'h080, 32'h3FF);
    oct = 1'b0;
    wr(REG_CTRL, 32'h0);
    cmd(OP_RES);
    st(32'h080, ALL);
    cmd(OP_WREN);
    op(OP_SE, 3, 32'h40000, 0, 8'h00);
    cmd(OP_SUSP);
    st(32'h040, 32'hFF);
    repeat (LAT) @(posedge clk);
    st(32'h0C0, M9);
    cmd(OP_WREN);
    op(OP_PP4, 4, 32'h40010, 1, 8'h11);
    st(32'h2D0, 32'h2FF);
    wr(REG_CLR, 32'h0);
    wq.push_back({32'h60010, 8'h22});
    op(OP_PP4, 4, 32'h60010, 1, 8'h22);
    cmd(OP_SUSP);
    repeat (LAT) @(posedge clk);
    st(32'h0C4, M9);
    cmd(OP_RES);
    st(32'h140, M9);
    repeat (PP) @(posedge clk);
    st(32'h0C0, M9);
    eq.push_back({EK_SEC, 32'h40000});
    cmd(OP_RES);
    st(32'h100, M9);
    wait_ers(32'h0, SE);
    st(32'h080, ALL);
    a = $urandom & 32'h00FFFFFF;
    cmd(OP_WREN);
    eq.push_back({EK_4K, a});
    op(OP_SSE4K, 3, a, 0, 8'h00);
    repeat (SSE - 32'h78) @(posedge clk);
    cmd(OP_SUSP);
    wait_ers(32'h0, 32'hC8);
    st(32'h080, ALL);
    print_verdict();
  end
endmodule
bind flash_seq flash_seq_asserts i_flash_seq_asserts (.clk(clk), .rst(rst), .cs_n(cs_n),
  .sclk(sclk), .serial_io_lines(serial_io_lines), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .arr_fail(arr_fail), .arr_erase(arr_erase), .arr_erase_kind(arr_erase_kind),
  .arr_erase_addr(arr_erase_addr), .arr_we(arr_we), .arr_waddr(arr_waddr),
  .arr_wdata(arr_wdata));
`default_nettype wire
